// *** hdl/sfpc_core.sv ***
/*
 * serial frame and parity control: control register, frame transmitter
 * and receiver with parity, mute wake-up, low power stop and interrupt.
 * assumes: software on a plain register port, a remote transceiver on
 * rxd/txd, one 10 MHz clock, asynchronous active low reset.
 */
// Local design decisions: the plain strobed port and the register addresses.
`timescale 1ns/1ns
`default_nettype none

module sfpc_core
   import sfpc_pkg::*;
(
   input  wire logic          clk,
   input  wire logic          rst_b,
   input  wire sfpc_bus_req_s bus_req,
   output logic [7:0]         rd_data,
   input  wire logic          rxd,
   output logic               txd,
   output logic               txd_en,
   output logic               irq
);
   // ===========================================================
   // state
   logic [7:0]       ctrl;
   logic [7:0]       baud_div;
   logic [7:0]       tdr, rdr;
   logic             tdr_full, rdr_full, pe_flag, st_seen, mute;
   logic [EVT_W-1:0] evt, mask;
   sfpc_tx_e         tx_st;
   logic [10:0]      tx_shift;
   logic [3:0]       tx_left;
   logic [7:0]       tx_cnt;
   sfpc_rx_e         rx_st;
   logic [8:0]       rx_shift;
   logic [3:0]       rx_left, idle_bits;
   logic [7:0]       rx_cnt;
   logic             rx_w9, rx_pce, rx_ps;
   logic             rxs;

   // ===========================================================
   // register port decode
   wire wr_ctrl  = bus_req.wr && bus_req.addr == REG_CTRL_ONE;
   wire wr_data  = bus_req.wr && bus_req.addr == REG_DATA;
   wire wr_baud  = bus_req.wr && bus_req.addr == REG_BAUD;
   wire wr_evt   = bus_req.wr && bus_req.addr == REG_EVENT;
   wire wr_mask  = bus_req.wr && bus_req.addr == REG_MASK;
   wire wr_ct2   = bus_req.wr && bus_req.addr == REG_CTRL_TWO;
   wire rd_stat  = bus_req.rd && bus_req.addr == REG_STATUS;
   wire rd_dreg  = bus_req.rd && bus_req.addr == REG_DATA;
   wire data_acc = (bus_req.wr || bus_req.rd) && bus_req.addr == REG_DATA;

   wire lpd   = ctrl[CTL_LPD];
   wire word9 = ctrl[CTL_WORD9];
   wire [7:0] status = {5'h00, ~tdr_full, rdr_full, pe_flag};

   // read data mux, unmapped offsets read zero
   logic [7:0] rd_mux;
   always_comb begin
      unique case (bus_req.addr)
         REG_CTRL_ONE: rd_mux = ctrl;
         REG_STATUS:   rd_mux = status;
         REG_DATA:     rd_mux = rdr;
         REG_BAUD:     rd_mux = baud_div;
         REG_EVENT:    rd_mux = {5'h00, evt};
         REG_MASK:     rd_mux = {5'h00, mask};
         REG_CTRL_TWO: rd_mux = {7'h00, mute};
         default:      rd_mux = 8'h00;
      endcase
   end

   // ===========================================================
   // transmit frame build, settings caught at frame start
   wire [8:0] tx_raw = {ctrl[CTL_TX9], tdr};
   logic      tx_pbit;
   sfpc_parity u_tx_par (
      .word  (tx_raw),
      .word9 (word9),
      .odd   (ctrl[CTL_PS]),
      .pbit  (tx_pbit)
   );
   wire [8:0] tx_word = !ctrl[CTL_PCE] ? tx_raw :
                        word9 ? {tx_pbit, tdr} :
                        {1'b0, tx_pbit, tdr[6:0]};
   wire [10:0] tx_frame = word9 ? {1'b1, tx_word, 1'b0} :
                          {2'b11, tx_word[7:0], 1'b0};
   wire tx_load = tx_st == TX_IDLE && tdr_full && !lpd;
   wire tx_tick = tx_st == TX_SHIFT && tx_cnt == 8'h00;
   wire tx_done = tx_tick && tx_left == 4'h0;

   // ===========================================================
   // receive path
   sfpc_sync u_rx_sync (
      .clk   (clk),
      .rst_b (rst_b),
      .d     (rxd),
      .q     (rxs)
   );
   wire       rx_tick = rx_cnt == 8'h00;
   wire [8:0] rx_word = rx_w9 ? rx_shift : {1'b0, rx_shift[8:1]};
   wire       rx_msb  = rx_w9 ? rx_word[8] : rx_word[7];
   logic      rx_pbit;
   sfpc_parity u_rx_par (
      .word  (rx_word),
      .word9 (rx_w9),
      .odd   (rx_ps),
      .pbit  (rx_pbit)
   );
   wire rx_perr  = rx_pce && (rx_pbit != rx_msb);
   wire rx_end   = rx_st == RX_STOP && rx_tick;
   wire addr_hit = mute && ctrl[CTL_WAKE] && rx_msb;
   wire deliver  = rx_end && (!mute || addr_hit);
   wire pe_set   = deliver && rx_perr;
   wire [3:0] frame_len = word9 ? FRAME_BITS_9 : FRAME_BITS_8;
   wire idle_wake = mute && !ctrl[CTL_WAKE] && idle_bits == frame_len;
   wire [EVT_W-1:0] evt_set = {tx_done, deliver, pe_set};

   // ===========================================================
   // register file and flags, hardware set wins over clear
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         ctrl     <= CTRL_RST;
         baud_div <= BAUD_RST;
         mask     <= MASK_RST;
         tdr      <= 8'h00;
         rdr      <= 8'h00;
         tdr_full <= 1'b0;
         rdr_full <= 1'b0;
         pe_flag  <= 1'b0;
         st_seen  <= 1'b0;
         mute     <= 1'b0;
         evt      <= 3'h0;
      end else begin
         if (wr_ctrl)
            ctrl[CTL_TX9:0] <= bus_req.wdata[CTL_TX9:0];
         if (deliver && rx_w9)
            ctrl[CTL_RX9] <= rx_word[8];
         else if (wr_ctrl)
            ctrl[CTL_RX9] <= bus_req.wdata[CTL_RX9];
         if (wr_baud)
            baud_div <= bus_req.wdata;
         if (wr_mask)
            mask <= bus_req.wdata[EVT_W-1:0];
         if (wr_data)
            tdr <= bus_req.wdata;
         tdr_full <= wr_data || (tdr_full && !tx_load);
         if (deliver)
            rdr <= rx_word[7:0];
         rdr_full <= deliver || (rdr_full && !rd_dreg);
         pe_flag  <= pe_set || (pe_flag && !(st_seen && data_acc));
         st_seen  <= rd_stat || (st_seen && !data_acc);
         mute     <= (wr_ct2 ? bus_req.wdata[CT2_MUTE] : mute)
                     && !idle_wake && !(rx_end && addr_hit);
         evt      <= evt_set | (evt & ~(wr_evt ? bus_req.wdata[2:0] : 3'h0));
      end
   end

   // ===========================================================
   // registered outputs: read data, interrupt, line enable
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         rd_data <= 8'h00;
         irq     <= 1'b0;
         txd_en  <= 1'b0;
      end else begin
         rd_data <= bus_req.rd ? rd_mux : 8'h00;
         irq     <= (ctrl[CTL_PIE] && pe_flag) || |(evt & mask);
         txd_en  <= !(lpd && tx_st == TX_IDLE);
      end
   end

   // ===========================================================
   // transmitter: start bit on load, one bit per prescaler wrap
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         tx_st    <= TX_IDLE;
         tx_shift <= 11'h7FF;
         tx_left  <= 4'h0;
         tx_cnt   <= 8'h00;
         txd      <= 1'b1;
      end else if (tx_load) begin
         tx_st    <= TX_SHIFT;
         txd      <= 1'b0;
         tx_shift <= {1'b1, tx_frame[10:1]};
         tx_left  <= frame_len - 4'h1;
         tx_cnt   <= baud_div;
      end else if (tx_done) begin
         tx_st <= TX_IDLE;
      end else if (tx_tick) begin
         txd      <= tx_shift[0];
         tx_shift <= {1'b1, tx_shift[10:1]};
         tx_left  <= tx_left - 4'h1;
         tx_cnt   <= baud_div;
      end else if (tx_st == TX_SHIFT) begin
         tx_cnt <= tx_cnt - 8'h01;
      end
   end

   // ===========================================================
   // receiver: mid-bit sampling, idle count for wake-up
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         rx_st     <= RX_IDLE;
         rx_cnt    <= 8'h00;
         rx_left   <= 4'h0;
         rx_shift  <= 9'h000;
         idle_bits <= 4'h0;
         rx_w9     <= 1'b0;
         rx_pce    <= 1'b0;
         rx_ps     <= 1'b0;
      end else begin
         unique case (rx_st)
            RX_IDLE: begin
               if (lpd) begin
                  rx_cnt    <= baud_div;
                  idle_bits <= 4'h0;
               end else if (!rxs) begin
                  rx_st     <= RX_START;
                  rx_cnt    <= {1'b0, baud_div[7:1]};
                  idle_bits <= 4'h0;
                  rx_w9     <= word9;
                  rx_pce    <= ctrl[CTL_PCE];
                  rx_ps     <= ctrl[CTL_PS];
               end else if (rx_tick) begin
                  rx_cnt <= baud_div;
                  if (idle_bits != IDLE_SAT)
                     idle_bits <= idle_bits + 4'h1;
               end else begin
                  rx_cnt <= rx_cnt - 8'h01;
               end
            end
            RX_START: begin
               if (rx_tick) begin
                  rx_st   <= rxs ? RX_IDLE : RX_DATA;
                  rx_cnt  <= baud_div;
                  rx_left <= rx_w9 ? DATA_BITS_9 : DATA_BITS_8;
               end else begin
                  rx_cnt <= rx_cnt - 8'h01;
               end
            end
            RX_DATA: begin
               if (rx_tick) begin
                  rx_shift <= {rxs, rx_shift[8:1]};
                  rx_left  <= rx_left - 4'h1;
                  rx_cnt   <= baud_div;
                  if (rx_left == 4'h1)
                     rx_st <= RX_STOP;
               end else begin
                  rx_cnt <= rx_cnt - 8'h01;
               end
            end
            RX_STOP: begin
               if (rx_tick) begin
                  rx_st  <= RX_IDLE;
                  rx_cnt <= baud_div;
               end else begin
                  rx_cnt <= rx_cnt - 8'h01;
               end
            end
         endcase
      end
   end

   // ===========================================================
   // checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);

   sequence s_tx_load;
      tx_load;
   endsequence
   sequence s_pe_release;
      st_seen && data_acc && !pe_set;
   endsequence

   a_rx_ninth_bit: assert property (deliver && rx_w9 |=>
      ctrl[CTL_RX9] == $past(rx_word[8])) else $error("ninth bit lost");
   a_tx_ninth_bit: assert property (s_tx_load ##0 word9 &&
      !ctrl[CTL_PCE] |=> tx_shift[8] == $past(ctrl[CTL_TX9]))
      else $error("ninth bit not sent");
   a_low_power_stop: assert property (lpd && tx_st == TX_IDLE |=>
      tx_st == TX_IDLE && !txd_en) else $error("low power ignored");
   a_start_bit: assert property (s_tx_load |=> !txd ##1
      tx_st == TX_SHIFT) else $error("no start bit");
   a_tx_parity: assert property (s_tx_load ##0 ctrl[CTL_PCE] |=>
      (word9 ? ^tx_shift[8:0] : ^tx_shift[7:0]) == $past(ctrl[CTL_PS]))
      else $error("parity bit wrong");
   a_pe_set: assert property (pe_set |=> pe_flag &&
      evt[EVT_PE]) else $error("parity error missed");
   a_pe_clear: assert property (s_pe_release |=> !pe_flag)
      else $error("parity flag not cleared");
   a_irq_parity: assert property (ctrl[CTL_PIE] && pe_flag |=> irq)
      else $error("parity interrupt missing");
   a_irq_quiet: assert property (!(ctrl[CTL_PIE] && pe_flag) &&
      !(|(evt & mask)) |=> !irq) else $error("spurious interrupt");
   a_rx_cfg_hold: assert property (rx_st != RX_IDLE &&
      $stable(rx_st) |-> $stable(rx_pce) && $stable(rx_ps))
      else $error("parity setting changed mid byte");
endmodule : sfpc_core

`default_nettype wire

// *** include/sfpc_pkg.sv ***
/*
 * package of the serial frame and parity control block: register offsets,
 * field positions, reset values, frame sizes, state codes and the bus
 * request carrier.
 * assumes: one 10 MHz clock domain, registers reached over a plain port.
 */
package sfpc_pkg;

   // ===========================================================
   // register offsets
   localparam logic [2:0] REG_CTRL_ONE = 3'h0; // serial_frame_control_one
   localparam logic [2:0] REG_STATUS   = 3'h1; // serial_status_register
   localparam logic [2:0] REG_DATA     = 3'h2; // serial_data_register
   localparam logic [2:0] REG_BAUD     = 3'h3; // cycles per bit minus one
   localparam logic [2:0] REG_EVENT    = 3'h4; // sticky events, write one
   localparam logic [2:0] REG_MASK     = 3'h5; // event mask
   localparam logic [2:0] REG_CTRL_TWO = 3'h6; // mute control

   // ===========================================================
   // field positions
   localparam int CTL_RX9   = 7; // receive_ninth_bit
   localparam int CTL_TX9   = 6; // transmit_ninth_bit
   localparam int CTL_LPD   = 5; // low_power_disable
   localparam int CTL_WORD9 = 4; // word length
   localparam int CTL_WAKE  = 3; // wake-up method
   localparam int CTL_PCE   = 2; // parity_control_enable
   localparam int CTL_PS    = 1; // parity_select
   localparam int CTL_PIE   = 0; // parity_interrupt_enable
   localparam int ST_PE     = 0; // parity_error_flag
   localparam int ST_RXFULL = 1;
   localparam int ST_TXEMPT = 2;
   localparam int CT2_MUTE  = 0;
   localparam int EVT_PE    = 0;
   localparam int EVT_RX    = 1;
   localparam int EVT_TX    = 2;
   localparam int EVT_W     = 3;

   // ===========================================================
   // reset values
   localparam logic [7:0]       CTRL_RST = 8'h00;
   localparam logic [7:0]       BAUD_RST = 8'h0F;
   localparam logic [EVT_W-1:0] MASK_RST = 3'h0;

   // ===========================================================
   // frame sizes in bit times
   localparam logic [3:0] DATA_BITS_8  = 4'h8;
   localparam logic [3:0] DATA_BITS_9  = 4'h9;
   localparam logic [3:0] FRAME_BITS_8 = 4'hA;
   localparam logic [3:0] FRAME_BITS_9 = 4'hB;
   localparam logic [3:0] IDLE_SAT     = 4'hF;

   // ===========================================================
   // states and carriers
   typedef enum logic [0:0] {TX_IDLE = 1'b0, TX_SHIFT = 1'b1} sfpc_tx_e;
   typedef enum logic [1:0] {
      RX_IDLE  = 2'b00,
      RX_START = 2'b01,
      RX_DATA  = 2'b10,
      RX_STOP  = 2'b11
   } sfpc_rx_e;

   typedef struct packed {
      logic [2:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } sfpc_bus_req_s;

endpackage : sfpc_pkg

// *** hdl/sfpc_sync.sv ***
/*
 * two flip-flop synchroniser for the receive pin.
 * assumes: input is asynchronous to clk; idles high like a serial line.
 */
`timescale 1ns/1ns
`default_nettype none

module sfpc_sync (
   input  wire logic clk,
   input  wire logic rst_b,
   input  wire logic d,
   output logic      q
);
   logic meta;

   // ===========================================================
   // first stage feeds only the second
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         meta <= 1'b1;
         q    <= 1'b1;
      end else begin
         meta <= d;
         q    <= meta;
      end
   end
endmodule : sfpc_sync

`default_nettype wire

// *** hdl/sfpc_parity.sv ***
/*
 * parity bit for the bits below the most significant data position.
 * assumes: word9 selects nine data bits, odd selects odd parity.
 */
`timescale 1ns/1ns
`default_nettype none

module sfpc_parity (
   input  wire logic [8:0] word,
   input  wire logic       word9,
   input  wire logic       odd,
   output logic            pbit
);
   // ===========================================================
   // bit that makes the count of ones even, or odd when asked
   assign pbit = (word9 ? ^word[7:0] : ^word[6:0]) ^ odd;
endmodule : sfpc_parity

`default_nettype wire

// *** sim/sfpc_remote.sv ***
/*
 * remote transceiver model: sends frames on rxd, captures txd frames.
 * assumes: bit time of BIT_CLKS clocks, line idles high between frames.
 */
`timescale 1ns/1ns
`default_nettype none

module sfpc_remote #(
   parameter int BIT_CLKS = 16
) (
   input  wire logic clk,
   input  wire logic txd,
   output logic      rxd
);
   // ===================================
   // line driver, high while idle
   initial rxd = 1'b1;

   // start bit, n data bits lsb first, one stop bit
   task automatic send(input logic [8:0] w, input int n);
      @(posedge clk);
      rxd <= 1'b0;
      repeat (BIT_CLKS) @(posedge clk);
      for (int i = 0; i < n; i++) begin
         rxd <= w[i];
         repeat (BIT_CLKS) @(posedge clk);
      end
      rxd <= 1'b1;
      repeat (BIT_CLKS) @(posedge clk);
   endtask : send

   // waits lim clocks for a start bit, samples each bit mid-cell
   task automatic catch_frame(input int n, input int lim,
                              output logic [8:0] w, output logic ok);
      int t;
      w = 9'h000;
      ok = 1'b0;
      for (t = 0; t < lim && txd !== 1'b0; t++) @(posedge clk);
      if (txd !== 1'b0) return;
      repeat (BIT_CLKS / 2) @(posedge clk);
      ok = (txd === 1'b0);
      for (int i = 0; i < n; i++) begin
         repeat (BIT_CLKS) @(posedge clk);
         w[i] = txd;
      end
      repeat (BIT_CLKS) @(posedge clk);
      ok = ok & (txd === 1'b1);
   endtask : catch_frame
endmodule : sfpc_remote
`default_nettype wire

// *** sim/sfpc_core_test.sv ***
/*
 * self-checking bench of the frame and parity control block.
 * assumes: reset baud value, remote model on the serial pins.
 */
`timescale 1ns/1ns
`default_nettype none

module sfpc_core_test;
   import sfpc_pkg::*;
   localparam int BIT = int'(BAUD_RST) + 1;
   typedef struct packed {
      logic [7:0] ctrl;
      logic [7:0] data;
      logic [8:0] exp;
      logic       nine;
   } sfpc_row_s;

   logic          clk;
   logic          rst_b;
   sfpc_bus_req_s req;
   logic [7:0]    rd_data;
   logic          rxd;
   logic          txd;
   logic          txd_en;
   logic          irq;
   int            errors;
   int            samples_checked;
   logic [7:0]    v;
   logic [8:0]    w;
   logic          ok;
   sfpc_row_s     rows [8] = '{
      '{8'h00, 8'h35, 9'h035, 1'b0}, '{8'h50, 8'h35, 9'h135, 1'b1},
      '{8'h10, 8'h35, 9'h035, 1'b1}, '{8'h04, 8'h07, 9'h087, 1'b0},
      '{8'h06, 8'h07, 9'h007, 1'b0}, '{8'h14, 8'h07, 9'h107, 1'b1},
      '{8'h16, 8'h07, 9'h007, 1'b1}, '{8'h56, 8'h07, 9'h007, 1'b1}};

   sfpc_core sfpc_core_inst (.clk(clk), .rst_b(rst_b), .bus_req(req),
      .rd_data(rd_data), .rxd(rxd), .txd(txd), .txd_en(txd_en),
      .irq(irq));
   sfpc_remote #(.BIT_CLKS(BIT)) sfpc_remote_inst (.clk(clk),
      .txd(txd), .rxd(rxd));

   // ===================================
   // clock
   initial clk = 1'b0;
   always #50 clk = ~clk;

   task automatic chk(input string n, input logic [8:0] e, g);
      samples_checked++;
      if (g !== e) begin
         errors++;
         $display("[FAIL] %s expected %h seen %h", n, e, g);
      end
   endtask : chk

   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge clk);
      req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge clk);
      req.wr <= 1'b0;
   endtask : wr

   // read data stand only in the cycle after the strobe
   task automatic rd(input logic [2:0] a, output logic [7:0] d);
      @(posedge clk);
      req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge clk);
      req.rd <= 1'b0;
      @(negedge clk);
      d = rd_data;
   endtask : rd

   // polls status until a word is ready, returns last status
   task automatic wait_rx(output logic [7:0] s);
      for (int i = 0; i < 40; i++) begin
         rd(REG_STATUS, s);
         if (s[ST_RXFULL] === 1'b1) return;
      end
      errors++;
      results();
   endtask : wait_rx

   // changes control in mid frame, frame keeps the old format
   task automatic tx_mid(input logic [7:0] d, c, input logic [8:0] e);
      wr(REG_DATA, d);
      fork
         sfpc_remote_inst.catch_frame(8, 600, w, ok);
         begin
            repeat (40) @(posedge clk);
            wr(REG_CTRL_ONE, c);
         end
      join
      chk("mid frame", e, w);
      $display("mid frame test done");
   endtask : tx_mid

   task results;
      $display("checked %0d mismatches %0d", samples_checked, errors);
      if (errors == 0 && samples_checked > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : results

   // ===================================
   // main sequence
   initial begin
      req = '0;
      rst_b = 1'b0;
      errors = 0;
      samples_checked = 0;
      repeat (5) @(posedge clk);
      chk("rst txd", 9'h001, 9'(txd));
      chk("rst txd_en", 9'h000, 9'(txd_en));
      chk("rst irq", 9'h000, 9'(irq));
      rst_b <= 1'b1;
      rd(REG_CTRL_ONE, v);
      chk("ctrl rst", 9'(CTRL_RST), 9'(v));
      rd(REG_BAUD, v);
      chk("baud rst", 9'(BAUD_RST), 9'(v));
      rd(REG_MASK, v);
      chk("mask rst", 9'(MASK_RST), 9'(v));
      @(negedge clk);
      chk("rd idle", 9'h000, 9'(rd_data));
      rd(REG_STATUS, v);
      chk("status rst", 9'h004, 9'(v));
      wr(REG_BAUD, 8'h07);
      rd(REG_BAUD, v);
      chk("baud rw", 9'h007, 9'(v));
      wr(REG_BAUD, BAUD_RST);
      chk("txd_en on", 9'h001, 9'(txd_en));
      wr(3'h7, 8'hFF);
      rd(3'h7, v);
      chk("unmapped", 9'h000, 9'(v));
      $display("reset test done");
      foreach (rows[k]) begin
         wr(REG_CTRL_ONE, rows[k].ctrl);
         wr(REG_DATA, rows[k].data);
         sfpc_remote_inst.catch_frame(8 + rows[k].nine, 600, w, ok);
         chk("tx frame", rows[k].exp, w);
         chk("tx stop", 9'h001, 9'(ok));
         sfpc_remote_inst.send(rows[k].exp, 8 + rows[k].nine);
         wait_rx(v);
         chk("rx parity", 9'h000, 9'(v[ST_PE]));
         rd(REG_DATA, v);
         chk("rx data", 9'(rows[k].exp[7:0]), 9'(v));
         rd(REG_CTRL_ONE, v);
         chk("ctrl", 9'(rows[k].ctrl[6:0]), 9'(v[6:0]));
         if (rows[k].nine)
            chk("rx ninth", 9'(rows[k].exp[8]), 9'(v[7]));
      end
      $display("row tests done");
      // parity error, flag clear sequence, interrupt and mask
      wr(REG_EVENT, 8'h07);
      wr(REG_CTRL_ONE, 8'h05);
      sfpc_remote_inst.send(9'h007, 8);
      wait_rx(v);
      chk("pe set", 9'h001, 9'(v[ST_PE]));
      chk("pe irq", 9'h001, 9'(irq));
      rd(REG_DATA, v);
      rd(REG_STATUS, v);
      chk("pe clear", 9'h000, 9'(v[ST_PE]));
      chk("irq clear", 9'h000, 9'(irq));
      wr(REG_CTRL_ONE, 8'h04);
      sfpc_remote_inst.send(9'h007, 8);
      wait_rx(v);
      chk("pe no irq", 9'h000, 9'(irq));
      rd(REG_EVENT, v);
      chk("events", 9'h003, 9'(v));
      wr(REG_MASK, 8'h01);
      repeat (2) @(negedge clk);
      chk("mask irq", 9'h001, 9'(irq));
      wr(REG_EVENT, 8'h01);
      repeat (2) @(negedge clk);
      chk("w1c irq", 9'h000, 9'(irq));
      rd(REG_EVENT, v);
      chk("w1c", 9'h002, 9'(v));
      rd(REG_DATA, v);
      $display("parity error test done");
      // format changes wait for the frame end
      tx_mid(8'h07, 8'h06, 9'h087);
      tx_mid(8'h07, 8'h02, 9'h007);
      tx_mid(8'h87, 8'h20, 9'h087);
      // low power: no new frame, line enable off
      repeat (BIT) @(posedge clk);
      chk("lp txd_en", 9'h000, 9'(txd_en));
      wr(REG_DATA, 8'h55);
      sfpc_remote_inst.catch_frame(8, 300, w, ok);
      chk("lp blocked", 9'h000, 9'(ok));
      tx_mid(8'h55, 8'h00, 9'h055);
      $display("low power test done");
      // wake on address mark, idle ignored
      wr(REG_CTRL_ONE, 8'h08);
      wr(REG_CTRL_TWO, 8'h01);
      sfpc_remote_inst.send(9'h035, 8);
      repeat (12 * BIT) @(posedge clk);
      rd(REG_STATUS, v);
      chk("mute drop", 9'h000, 9'(v[ST_RXFULL]));
      rd(REG_CTRL_TWO, v);
      chk("mute hold", 9'h001, 9'(v[CT2_MUTE]));
      sfpc_remote_inst.send(9'h0B5, 8);
      wait_rx(v);
      rd(REG_DATA, v);
      chk("mark word", 9'h0B5, 9'(v));
      rd(REG_CTRL_TWO, v);
      chk("mark wake", 9'h000, 9'(v[CT2_MUTE]));
      // wake on idle line
      wr(REG_CTRL_ONE, 8'h00);
      wr(REG_CTRL_TWO, 8'h01);
      repeat (12 * BIT) @(posedge clk);
      rd(REG_CTRL_TWO, v);
      chk("idle wake", 9'h000, 9'(v[CT2_MUTE]));
      $display("wake test done");
      // mid-run reset returns registers and outputs to rest
      wr(REG_CTRL_ONE, 8'h20);
      wr(REG_CTRL_TWO, 8'h01);
      @(posedge clk);
      rst_b <= 1'b0;
      repeat (5) @(posedge clk);
      chk("mid rst txd_en", 9'h000, 9'(txd_en));
      chk("mid rst irq", 9'h000, 9'(irq));
      chk("mid rst txd", 9'h001, 9'(txd));
      rst_b <= 1'b1;
      rd(REG_CTRL_ONE, v);
      chk("mid rst ctrl", 9'(CTRL_RST), 9'(v));
      rd(REG_CTRL_TWO, v);
      chk("mid rst mute", 9'h000, 9'(v));
      chk("mid rst txd_en on", 9'h001, 9'(txd_en));
      $display("mid reset test done");
      results();
   end
endmodule : sfpc_core_test
`default_nettype wire
